// ==== src/csw_regs.vh ====
// Register map, field positions, reset values and decode constants
`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSW_OFS_AREA0_CTRL   8'h00
`define CSW_OFS_AREA1_CTRL   8'h04
`define CSW_OFS_AREA2_CTRL   8'h08
`define CSW_OFS_AREA3_CTRL   8'h0c
`define CSW_OFS_DEFAULT_CTRL 8'h10
`define CSW_OFS_START0       8'h14
`define CSW_OFS_START1       8'h18
`define CSW_OFS_START2       8'h1c
`define CSW_OFS_START3       8'h20
`define CSW_OFS_MASK0        8'h24
`define CSW_OFS_MASK1        8'h28
`define CSW_OFS_MASK2        8'h2c
`define CSW_OFS_MASK3        8'h30
`define CSW_OFS_P6_FUNC      8'h34
`define CSW_OFS_P6_DIR       8'h38
`define CSW_OFS_P6_DATA      8'h3c
`define CSW_OFS_STATUS       8'h40

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CSW_WAIT_LSB         0
`define CSW_WAIT_MSB         2
`define CSW_BUS8_BIT         3
`define CSW_A2_DECODE_BIT    6
`define CSW_ENABLE_BIT       7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSW_RST_AREA_CTRL    8'h00
`define CSW_RST_AREA2_CTRL   8'h80
`define CSW_RST_DEFAULT_CTRL 8'h00
`define CSW_RST_ADDR         8'h00
`define CSW_RST_P6           4'h0

// ----------------------------------------------------------------
// Wait codes and fixed wait counts
// ----------------------------------------------------------------
`define CSW_W_TWO            3'h0
`define CSW_W_ONE            3'h1
`define CSW_W_ONE_PIN        3'h2
`define CSW_W_ZERO           3'h3
`define CSW_W_ZERO_PIN       3'h4
`define CSW_W_THREE          3'h5
`define CSW_W_FOUR           3'h6
`define CSW_W_EIGHT          3'h7
`define CSW_CNT_0            4'h0
`define CSW_CNT_1            4'h1
`define CSW_CNT_2            4'h2
`define CSW_CNT_3            4'h3
`define CSW_CNT_4            4'h4
`define CSW_CNT_8            4'h8

// ----------------------------------------------------------------
// Address ranges
// ----------------------------------------------------------------
`define CSW_A2_FIX1_LO       24'h000fe0
`define CSW_A2_FIX1_HI       24'h000fff
`define CSW_A2_FIX2_LO       24'h003000
`define CSW_INT_IO_LO        24'h000000
`define CSW_INT_IO_HI        24'h0000ff
`define CSW_INT_RAM_LO       24'h001000
`define CSW_INT_RAM_HI       24'h002fff

`endif

// ==== src/csw_area_match.v ====
// Start address and mask comparison for one programmable area
`timescale 1ns/1ps
module csw_area_match (
  input  wire [23:0] addr,
  input  wire [7:0]  start_addr,
  input  wire [7:0]  addr_mask,
  output wire        hit
);
  // Masked bits of the top address byte are don't care
  assign hit = (((addr[23:16] ^ start_addr) & ~addr_mask) == 8'h00);
endmodule // csw_area_match

// ==== src/csw_wait_seq.v ====
// Wait state sequencer for one bus cycle
`timescale 1ns/1ps
`include "csw_regs.vh"
module csw_wait_seq (
  input  wire       clk,
  input  wire       resetn,
  input  wire       start,
  input  wire [2:0] wait_code,
  input  wire       wait_n,
  output wire       busy,
  output wire       done
);
  reg       busy_reg;
  reg [3:0] cnt_reg;
  reg       samp_reg;
  reg [3:0] load_cnt;
  reg       load_samp;

  // ----------------------------------------------------------------
  // Wait code decode
  // ----------------------------------------------------------------
  always @* begin
    load_cnt  = `CSW_CNT_0;
    load_samp = 1'b0;
    case (wait_code)
      // [R2] Two fixed
      `CSW_W_TWO:      load_cnt = `CSW_CNT_2;
      // [R3] One fixed
      `CSW_W_ONE:      load_cnt = `CSW_CNT_1;
      // [R4] One then pin
      `CSW_W_ONE_PIN: begin
        load_cnt  = `CSW_CNT_1;
        load_samp = 1'b1;
      end
      // [R5] No waits
      `CSW_W_ZERO:     load_cnt = `CSW_CNT_0;
      // [R6] Pin only
      `CSW_W_ZERO_PIN: load_samp = 1'b1;
      // [R7] Long fixed
      `CSW_W_THREE:    load_cnt = `CSW_CNT_3;
      `CSW_W_FOUR:     load_cnt = `CSW_CNT_4;
      `CSW_W_EIGHT:    load_cnt = `CSW_CNT_8;
      default:         load_cnt = `CSW_CNT_2;
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  // [R1] Waits per area
  assign done = busy_reg && (cnt_reg == `CSW_CNT_0) &&
                (!samp_reg || wait_n);
  assign busy = busy_reg;

  always @(posedge clk) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
      cnt_reg  <= `CSW_CNT_0;
      samp_reg <= 1'b0;
    end else if (!busy_reg) begin
      if (start) begin
        busy_reg <= 1'b1;
        cnt_reg  <= load_cnt;
        samp_reg <= load_samp;
      end
    end else if (cnt_reg != `CSW_CNT_0) begin
      cnt_reg <= cnt_reg - `CSW_CNT_1;
    end else if (done) begin
      busy_reg <= 1'b0;
      samp_reg <= 1'b0;
    end
  end
endmodule // csw_wait_seq

// ==== src/csw_ctrl.v ====
// Chip select and wait control with APB register access
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "csw_regs.vh"

// How it works
// [R1] Three low control bits pick the wait count for each area.
// [R2] Code 000 gives exactly two waits, wait pin ignored.
// [R3] Code 001 gives exactly one wait, wait pin ignored.
// [R4] Code 010 gives one wait then stretches while wait pin is low.
// [R5] Code 011 ends the cycle with no waits, wait pin ignored.
// [R6] Code 100 stretches at once while the wait pin is low.
// [R7] Codes 101, 110, 111 give three, four and eight fixed waits.
// [R8] Software writes only the eight listed wait codes.
// [R9] Reset puts every wait field at 000.
// [R10] Unmatched addresses use the always-on default area settings.
// [R11] Area 2 bit 6 picks fixed ranges or start and mask decode.
// [R12] Reset clears the area 2 decode select bit.
// [R13] Software sets start, then mask, then control registers.
// [R14] A chip select reaches its pin only when its function bit is 1.
// [R15] Internal I/O or RAM addresses assert no chip select.
// [R16] Reset clears port 6 function and direction registers.
// [R17] Bit 7 enables an area; only area 2 is enabled after reset.
// [R18] Bit 3 selects bus width: 0 is 16 bits, 1 is 8 bits.
// [R19] Software avoids read-modify-write on the control registers.
// [R20] Chip select holds low for the whole cycle including waits.
// [R21] Area 0 wins over 1, 2 and 3 when several match.
module csw_ctrl (
  input  wire        clk,
  input  wire        resetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        cpu_start,
  input  wire [23:0] cpu_addr,
  output wire        cpu_ready,
  output wire        cpu_done,
  output wire        cpu_bus8,
  output wire        cpu_internal,
  input  wire        wait_n,
  output wire [3:0]  p6_out,
  output wire [3:0]  p6_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0] ctrl_reg [0:3];
  reg  [7:0] start_reg [0:3];
  reg  [7:0] mask_reg [0:3];
  reg  [7:0] default_ctrl_reg;
  reg  [3:0] p6_func_reg;
  reg  [3:0] p6_dir_reg;
  reg  [3:0] p6_data_reg;
  reg  [3:0] cs_active_reg;
  reg        bus8_reg;
  reg        internal_reg;
  wire [3:0] area_hit;
  wire [3:0] area_en;
  wire [3:0] area_sel;
  wire       a2_fixed_hit;
  wire       in_internal;
  wire       apb_wr;
  wire       apb_rd;
  wire       seq_busy;
  wire       seq_done;
  wire       take;
  reg  [7:0] sel_ctrl;
  reg  [3:0] sel_onehot;
  reg        addr_ok;
  integer    i;

  // ----------------------------------------------------------------
  // APB strobes
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // ----------------------------------------------------------------
  // Address check
  // ----------------------------------------------------------------
  always @* begin
    case (paddr)
      `CSW_OFS_AREA0_CTRL:   addr_ok = 1'b1;
      `CSW_OFS_AREA1_CTRL:   addr_ok = 1'b1;
      `CSW_OFS_AREA2_CTRL:   addr_ok = 1'b1;
      `CSW_OFS_AREA3_CTRL:   addr_ok = 1'b1;
      `CSW_OFS_DEFAULT_CTRL: addr_ok = 1'b1;
      `CSW_OFS_START0:       addr_ok = 1'b1;
      `CSW_OFS_START1:       addr_ok = 1'b1;
      `CSW_OFS_START2:       addr_ok = 1'b1;
      `CSW_OFS_START3:       addr_ok = 1'b1;
      `CSW_OFS_MASK0:        addr_ok = 1'b1;
      `CSW_OFS_MASK1:        addr_ok = 1'b1;
      `CSW_OFS_MASK2:        addr_ok = 1'b1;
      `CSW_OFS_MASK3:        addr_ok = 1'b1;
      `CSW_OFS_P6_FUNC:      addr_ok = 1'b1;
      `CSW_OFS_P6_DIR:       addr_ok = 1'b1;
      `CSW_OFS_P6_DATA:      addr_ok = 1'b1;
      `CSW_OFS_STATUS:       addr_ok = 1'b1;
      default:               addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Area control registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      // [R9] Wait fields to 000
      // [R17] Only area 2 enabled
      // [R12] Fixed area 2 decode
      ctrl_reg[0]      <= `CSW_RST_AREA_CTRL;
      ctrl_reg[1]      <= `CSW_RST_AREA_CTRL;
      ctrl_reg[2]      <= `CSW_RST_AREA2_CTRL;
      ctrl_reg[3]      <= `CSW_RST_AREA_CTRL;
      default_ctrl_reg <= `CSW_RST_DEFAULT_CTRL;
    end else if (apb_wr) begin
      case (paddr)
        `CSW_OFS_AREA0_CTRL:   ctrl_reg[0]      <= pwdata[7:0];
        `CSW_OFS_AREA1_CTRL:   ctrl_reg[1]      <= pwdata[7:0];
        `CSW_OFS_AREA2_CTRL:   ctrl_reg[2]      <= pwdata[7:0];
        `CSW_OFS_AREA3_CTRL:   ctrl_reg[3]      <= pwdata[7:0];
        `CSW_OFS_DEFAULT_CTRL: default_ctrl_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start address and mask registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        start_reg[i] <= `CSW_RST_ADDR;
        mask_reg[i]  <= `CSW_RST_ADDR;
      end
    end else if (apb_wr) begin
      case (paddr)
        `CSW_OFS_START0: start_reg[0] <= pwdata[7:0];
        `CSW_OFS_START1: start_reg[1] <= pwdata[7:0];
        `CSW_OFS_START2: start_reg[2] <= pwdata[7:0];
        `CSW_OFS_START3: start_reg[3] <= pwdata[7:0];
        `CSW_OFS_MASK0:  mask_reg[0]  <= pwdata[7:0];
        `CSW_OFS_MASK1:  mask_reg[1]  <= pwdata[7:0];
        `CSW_OFS_MASK2:  mask_reg[2]  <= pwdata[7:0];
        `CSW_OFS_MASK3:  mask_reg[3]  <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port 6 registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      // [R16] Port 6 cleared
      p6_func_reg <= `CSW_RST_P6;
      p6_dir_reg  <= `CSW_RST_P6;
      p6_data_reg <= `CSW_RST_P6;
    end else if (apb_wr) begin
      case (paddr)
        `CSW_OFS_P6_FUNC: p6_func_reg <= pwdata[3:0];
        `CSW_OFS_P6_DIR:  p6_dir_reg  <= pwdata[3:0];
        `CSW_OFS_P6_DATA: p6_data_reg <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read data and error
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `CSW_OFS_P6_FUNC: prdata[3:0] <= p6_func_reg;
          `CSW_OFS_P6_DIR:  prdata[3:0] <= p6_dir_reg;
          `CSW_OFS_P6_DATA: prdata[3:0] <= p6_data_reg;
          `CSW_OFS_STATUS: begin
            prdata[0]   <= seq_busy;
            prdata[4:1] <= cs_active_reg;
            prdata[5]   <= bus8_reg;
            prdata[6]   <= internal_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Area decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : area
      csw_area_match u_match (
        .addr       (cpu_addr),
        .start_addr (start_reg[g]),
        .addr_mask  (mask_reg[g]),
        .hit        (area_hit[g])
      );
      // [R17] Master enable
      assign area_en[g] = ctrl_reg[g][`CSW_ENABLE_BIT];
    end
  endgenerate

  assign a2_fixed_hit =
    ((cpu_addr >= `CSW_A2_FIX1_LO) && (cpu_addr <= `CSW_A2_FIX1_HI)) ||
    (cpu_addr >= `CSW_A2_FIX2_LO);

  assign in_internal =
    ((cpu_addr >= `CSW_INT_IO_LO) && (cpu_addr <= `CSW_INT_IO_HI)) ||
    ((cpu_addr >= `CSW_INT_RAM_LO) && (cpu_addr <= `CSW_INT_RAM_HI));

  assign area_sel[0] = area_en[0] && area_hit[0];
  assign area_sel[1] = area_en[1] && area_hit[1];
  // [R11] Area 2 decode mode
  assign area_sel[2] = area_en[2] &&
    (ctrl_reg[2][`CSW_A2_DECODE_BIT] ? area_hit[2] : a2_fixed_hit);
  assign area_sel[3] = area_en[3] && area_hit[3];

  // ----------------------------------------------------------------
  // Priority select
  // ----------------------------------------------------------------
  always @* begin
    sel_onehot = 4'h0;
    // [R10] Default area settings
    sel_ctrl   = default_ctrl_reg;
    // [R21] Fixed priority
    if (area_sel[0]) begin
      sel_onehot = 4'h1;
      sel_ctrl   = ctrl_reg[0];
    end else if (area_sel[1]) begin
      sel_onehot = 4'h2;
      sel_ctrl   = ctrl_reg[1];
    end else if (area_sel[2]) begin
      sel_onehot = 4'h4;
      sel_ctrl   = ctrl_reg[2];
    end else if (area_sel[3]) begin
      sel_onehot = 4'h8;
      sel_ctrl   = ctrl_reg[3];
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencing
  // ----------------------------------------------------------------
  assign cpu_ready = !seq_busy;
  assign take      = cpu_start && !seq_busy;

  csw_wait_seq u_seq (
    .clk       (clk),
    .resetn    (resetn),
    .start     (take),
    .wait_code (sel_ctrl[`CSW_WAIT_MSB:`CSW_WAIT_LSB]),
    .wait_n    (wait_n),
    .busy      (seq_busy),
    .done      (seq_done)
  );

  assign cpu_done = seq_done;

  always @(posedge clk) begin
    if (!resetn) begin
      cs_active_reg <= 4'h0;
      bus8_reg      <= 1'b0;
      internal_reg  <= 1'b0;
    end else if (take) begin
      // [R15] Internal space blocks selects
      cs_active_reg <= in_internal ? 4'h0 : sel_onehot;
      // [R18] Bus width
      bus8_reg      <= sel_ctrl[`CSW_BUS8_BIT];
      internal_reg  <= in_internal;
    end else if (seq_done) begin
      // [R20] Held to cycle end
      cs_active_reg <= 4'h0;
    end
  end

  assign cpu_bus8     = bus8_reg;
  assign cpu_internal = internal_reg;

  // ----------------------------------------------------------------
  // Shared pins
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin
      // [R14] Function bit gates select
      assign p6_out[g]  = p6_func_reg[g] ? ~cs_active_reg[g]
                                         : p6_data_reg[g];
      assign p6_oe_n[g] = ~(p6_func_reg[g] | p6_dir_reg[g]);
    end
  endgenerate

endmodule // csw_ctrl

// ==== verification/csw_ctrl_assertions.sv ====
// Concurrent checks on the chip select and wait control ports
`timescale 1ns/1ps
module csw_ctrl_assertions (
  input wire        clk,
  input wire        resetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        cpu_start,
  input wire [23:0] cpu_addr,
  input wire        cpu_ready,
  input wire        cpu_done,
  input wire        cpu_bus8,
  input wire        cpu_internal,
  input wire        wait_n,
  input wire [3:0]  p6_out,
  input wire [3:0]  p6_oe_n
);
  // ----------------------------------------------------------
  // Shadow of the pin function register
  // ----------------------------------------------------------
  reg  [3:0] func_reg;
  wire [3:0] cs_act;
  assign cs_act = ~p6_out & func_reg;
  always @(posedge clk) begin
    if (!resetn)
      func_reg <= 4'h0;
    else if (psel && penable && pwrite && paddr == 8'h34)
      func_reg <= pwdata[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    cpu_start && cpu_ready;
  endsequence
  sequence s_end;
    cpu_done ##1 cpu_ready;
  endsequence
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  a_take_busy: assert property (s_take |=> !cpu_ready)
    else $error("cycle not started after take");
  a_done_ready: assert property (cpu_done |-> s_end)
    else $error("ready not back after done");
  a_done_gap: assert property (cpu_done |=> !cpu_done)
    else $error("done longer than one cycle");
  a_cs_steady: assert property (
    !cpu_ready && !cpu_done |=> cs_act == $past(cs_act))
    else $error("chip select changed mid cycle");
  a_idle_nocs: assert property (cpu_ready |-> cs_act == 4'h0)
    else $error("chip select outside a cycle");
  a_one_cs: assert property ($onehot0(cs_act))
    else $error("more than one chip select");
  a_int_nocs: assert property (
    cpu_internal && !cpu_ready |-> cs_act == 4'h0)
    else $error("chip select on internal access");
  a_rst_pins: assert property (
    $rose(resetn) |-> p6_oe_n == 4'hf && cpu_ready)
    else $error("pins not released by reset");
  a_wo_read: assert property (
    psel && !penable && !pwrite &&
    paddr <= 8'h30 && paddr[1:0] == 2'b00 |=>
    prdata == 32'h0 && !pslverr)
    else $error("write only register read nonzero");
endmodule // csw_ctrl_assertions

bind csw_ctrl csw_ctrl_assertions u_chk (
  .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_start(cpu_start), .cpu_addr(cpu_addr), .cpu_ready(cpu_ready),
  .cpu_done(cpu_done), .cpu_bus8(cpu_bus8),
  .cpu_internal(cpu_internal), .wait_n(wait_n), .p6_out(p6_out),
  .p6_oe_n(p6_oe_n)
);

// ==== verification/csw_ext_mem.sv ====
// External memory model that stretches selected accesses
`timescale 1ns/1ps
module csw_ext_mem (
  input  wire       clk,
  input  wire [3:0] p6_out,
  input  wire [3:0] p6_oe_n,
  input  wire [3:0] stretch,
  output wire       wait_n
);
  reg  [3:0] cnt_reg;
  wire       sel;
  assign sel = |(~p6_out & ~p6_oe_n);
  always @(posedge clk) begin
    if (!sel)
      cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hf)
      cnt_reg <= cnt_reg + 4'h1;
  end
  assign wait_n = !(sel && cnt_reg < stretch);
endmodule // csw_ext_mem

// ==== verification/tb_top.sv ====
// Self-checking bench for the chip select and wait control
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  mismatches++; $display("Error %0t: got %0h exp %0h", $time, a, b); \
  end end
module tb_top;
  reg         clk, resetn, psel, penable, pwrite, cpu_start;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg  [23:0] cpu_addr;
  reg  [3:0]  stretch;
  wire [31:0] prdata;
  wire        pready, pslverr, cpu_ready, cpu_done, cpu_bus8;
  wire        cpu_internal, wait_n;
  wire [3:0]  p6_out, p6_oe_n;
  int         mismatches, cmp_count, waits, r, c, s;
  reg  [31:0] rd;
  reg         er, b8, inn, b;
  reg  [3:0]  pins;
  reg  [15:0] seed;
  csw_ctrl uut (
    .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_start(cpu_start), .cpu_addr(cpu_addr),
    .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_bus8(cpu_bus8),
    .cpu_internal(cpu_internal), .wait_n(wait_n), .p6_out(p6_out),
    .p6_oe_n(p6_oe_n));
  csw_ext_mem u_mem (.clk(clk), .p6_out(p6_out), .p6_oe_n(p6_oe_n),
    .stretch(stretch), .wait_n(wait_n));
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function int exp_w(input [2:0] code, input int n);
    case (code)
      3'h0: exp_w = 2;
      3'h1: exp_w = 1;
      3'h2: exp_w = (n > 1) ? n : 1;
      3'h3: exp_w = 0;
      3'h4: exp_w = n;
      3'h5: exp_w = 3;
      3'h6: exp_w = 4;
      default: exp_w = 8;
    endcase
  endfunction
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task cyc(input [23:0] a, input [3:0] n);
    @(posedge clk);
    cpu_start <= 1'b1; cpu_addr <= a; stretch <= n;
    @(negedge clk);
    while (cpu_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cpu_start <= 1'b0;
    waits = 0;
    @(negedge clk);
    while (cpu_done !== 1'b1) begin
      waits++;
      @(negedge clk);
    end
    pins = p6_out; b8 = cpu_bus8; inn = cpu_internal;
  endtask
  task stop_test;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; cpu_start = 0; cpu_addr = 24'h0; stretch = 4'h0;
    mismatches = 0; cmp_count = 0; seed = 16'h701e;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h08, 32'h0);
    `CHK({rd, er}, 33'h0)
    `CHK(p6_oe_n, 4'hf)
    cyc(24'h100000, 4'h0);
    `CHK(waits, 2)
    `CHK(pins, 4'h0)
    apb(1'b1, 8'h34, 32'hf);
    cyc(24'h100000, 4'h3);
    `CHK(waits, 2)
    `CHK(pins, 4'hb)
    for (r = 0; r < 3; r++) begin
      for (c = 0; c < 8; c++) begin
        seed = lfsr(seed);
        s = seed[7:4] % 5;
        b = seed[8];
        apb(1'b1, 8'h08, {24'h0, 1'b1, 3'b000, b, c[2:0]});
        cyc({4'h4, seed[3:0], seed}, s[3:0]);
        `CHK(waits, exp_w(c[2:0], s))
        `CHK(b8, b)
        `CHK(pins, 4'hb)
      end
    end
    apb(1'b1, 8'h08, 32'h03);
    apb(1'b1, 8'h10, 32'h0b);
    cyc(24'h500000, 4'h3);
    `CHK({waits[3:0], b8, pins}, 9'h01f)
    apb(1'b1, 8'h14, 32'h01);
    apb(1'b1, 8'h24, 32'h00);
    apb(1'b1, 8'h00, 32'h8e);
    apb(1'b1, 8'h08, 32'h80);
    cyc(24'h01abcd, 4'h2);
    `CHK({waits[3:0], b8, pins}, 9'h09e)
    apb(1'b1, 8'h1c, 32'h20);
    apb(1'b1, 8'h2c, 32'h00);
    apb(1'b1, 8'h08, 32'hc5);
    cyc(24'h20f000, 4'h0);
    `CHK({waits[3:0], pins}, 8'h3b)
    cyc(24'h300000, 4'h0);
    `CHK({waits[3:0], pins}, 8'h0f)
    apb(1'b1, 8'h14, 32'h00);
    cyc(24'h000050, 4'h0);
    `CHK({waits[3:0], inn, pins}, 9'h09f)
    cyc(24'h001800, 4'h0);
    `CHK({inn, pins}, 5'h1f)
    apb(1'b1, 8'h34, 32'h0);
    apb(1'b1, 8'h38, 32'hf);
    apb(1'b1, 8'h3c, 32'ha);
    cyc(24'h000800, 4'h0);
    `CHK({inn, pins}, 5'h0a)
    `CHK(p6_oe_n, 4'h0)
    stop_test;
  end
endmodule // tb_top
